// ### fpq_host.sv
`timescale 1ns/10ps
// ==========================================================
// host controller model driving the flash pins
module fpq_host
  import fpq_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic [DATA_W-1:0] i_rdata,
  input  wire logic              i_rdata_oe,
  output logic                   o_sleep_pin,
  output logic                   o_cs_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_wdata
);
  initial begin
    o_sleep_pin = 1'b0;
    o_cs_n = 1'b1;
    o_we_n = 1'b1;
    o_oe_n = 1'b1;
    o_addr = '0;
    o_wdata = '0;
  end

  task automatic host_sleep(input logic lvl);
    @(posedge i_sys_clk);
    o_sleep_pin <= lvl;
  endtask : host_sleep

  // address and data held through the whole strobe
  task automatic host_write(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_cs_n <= 1'b0;
    o_we_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    o_we_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    o_wdata <= ~d;
    repeat (3) @(posedge i_sys_clk);
  endtask : host_write

  task automatic host_read(input logic [ADDR_W-1:0] a,
                           output logic [DATA_W:0] r);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_cs_n <= 1'b0;
    o_oe_n <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    r = {i_rdata_oe, i_rdata};
    o_oe_n <= 1'b1;
    o_cs_n <= 1'b1;
    @(posedge i_sys_clk);
  endtask : host_read
endmodule : fpq_host

// ### fpq_pkg.sv
package fpq_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_MHZ                  = 100;
  localparam int unsigned SLEEP_ENTRY_IDLE_NS      = 100;
  localparam int unsigned SLEEP_ENTRY_BUSY_US      = 20;
  localparam int unsigned SLEEP_EXIT_WAIT_US       = 75;
  localparam int unsigned SLEEP_ENTRY_IDLE_CYC =
    (SLEEP_ENTRY_IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLEEP_ENTRY_BUSY_CYC =
    SLEEP_ENTRY_BUSY_US * CLK_MHZ;
  localparam int unsigned SLEEP_EXIT_WAIT_CYC =
    SLEEP_EXIT_WAIT_US * CLK_MHZ;
  localparam int unsigned CNT_W = 14;

  // ==========================================================
  // bus widths and commands
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned QADDR_W = 7;
  localparam logic [ADDR_W-1:0] QUERY_ENTRY_ADDR = 24'h000055;
  localparam logic [7:0]        CMD_QUERY        = 8'h98;
  localparam logic [7:0]        CMD_RESET        = 8'hf0;
  localparam logic [7:0]        QUERY_DATA_HI    = 8'h00;

  // ==========================================================
  // boot layout codes
  localparam logic [7:0] LAYOUT_BOTTOM  = 8'h02;
  localparam logic [7:0] LAYOUT_TOP     = 8'h03;
  localparam logic [7:0] LAYOUT_UNIFORM = 8'h04;

  typedef enum logic [3:0] {
    FPQ_ACTIVE  = 4'b0001,
    FPQ_ENTER   = 4'b0010,
    FPQ_SLEEP   = 4'b0100,
    FPQ_WAKE    = 4'b1000
  } fpq_pwr_t;
endpackage : fpq_pkg

// ### fpq_rom.sv
`timescale 1ns/10ps
module fpq_rom
  import fpq_pkg::*;
(
  // table select
  input  wire logic [1:0]         i_layout,
  input  wire logic [fpq_pkg::QADDR_W-1:0] i_addr,
  output logic      [7:0]         o_data
);
  import fpq_pkg::*;

  // layout: 0 bottom boot, 1 top boot, 2 and 3 uniform
  logic boot;
  assign boot = (i_layout < 2'h2);

  always_comb begin
    case (i_addr)
      7'h10: o_data = 8'h51;
      7'h11: o_data = 8'h52;
      7'h12: o_data = 8'h59;
      7'h13: o_data = 8'h02;
      7'h15: o_data = 8'h40;
      7'h1b: o_data = 8'h17;
      7'h1c: o_data = 8'h19;
      7'h1d: o_data = 8'h85;
      7'h1e: o_data = 8'h95;
      7'h1f: o_data = 8'h08;
      7'h20: o_data = 8'h09;
      7'h21: o_data = 8'h0a;
      7'h22: o_data = 8'h12;
      7'h23: o_data = 8'h01;
      7'h24: o_data = 8'h01;
      7'h25: o_data = 8'h04;
      7'h27: o_data = 8'h19;
      7'h2a: o_data = 8'h06;
      7'h2c: o_data = boot ? 8'h02 : 8'h01;
      7'h2d: o_data = boot ? 8'h03 : 8'hff;
      7'h2f: o_data = boot ? 8'h80 : 8'h00;
      7'h30: o_data = boot ? 8'h00 : 8'h02;
      7'h31: o_data = boot ? 8'hfe : 8'h00;
      7'h34: o_data = boot ? 8'h02 : 8'h00;
      7'h40: o_data = 8'h50;
      7'h41: o_data = 8'h52;
      7'h42: o_data = 8'h49;
      7'h43: o_data = 8'h30;
      7'h44: o_data = 8'h30;
      7'h46: o_data = 8'h02;
      7'h47: o_data = 8'h01;
      7'h49: o_data = 8'h01;
      7'h4a: o_data = 8'h01;
      7'h4b: o_data = 8'h01;
      7'h4c: o_data = 8'h03;
      7'h4d: begin
        case (i_layout)
          2'h0:    o_data = LAYOUT_BOTTOM;
          2'h1:    o_data = LAYOUT_TOP;
          default: o_data = LAYOUT_UNIFORM;
        endcase
      end
      7'h4e: o_data = 8'h85;
      7'h50: o_data = 8'h01;
      default: o_data = 8'h00;
    endcase
  end
endmodule : fpq_rom

// ### fpq_sync.sv
`timescale 1ns/10ps
module fpq_sync #(
  // level held in both flops while reset is low
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // level in and out
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } fpq_sync_st_t;

  fpq_sync_st_t st_reg;
  fpq_sync_st_t st_next;

  always_comb begin
    st_next.stage1 = i_async;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.stage2;
endmodule : fpq_sync

// ### fpq_top.sv
`timescale 1ns/10ps
// Behaviour
// - sleep only while sleep pin high; internal circuitry then shut down.
// - after sleep pin falls, device operational again within 75 us.
// - chip select ignored while asleep.
// - program and erase rejected while asleep.
// - reset and sleep pin accepted in any order at power up.
// - sleep pin rise while idle enters sleep after 100 ns.
// - sleep pin rise while busy enters sleep after 20 us.
// - write 98h to word address 55h enters query mode.
// - query data on low byte, upper byte driven zero.
// - query mode held until the reset command is written or sleep is entered.
// - query 10h-12h return the ascii signature.
// - 15h points to extended table at 40h with its signature.
// - timing exponents at 1fh, 20h, 22h.
// - block erase exponent at 21h and maximum factors 23h-26h.
// - 27h returns the device size exponent.
// - 2ah returns multi-byte write exponent, 2bh zero.
// - 2ch returns region count by variant.
// - region 1 record at 2dh by variant.
// - region 2 by variant, regions 3 and 4 zero.
// - extended words 46h-4bh.
// - 4ch page read code, 4fh zero.
// - 4dh boot layout code.
module fpq_top
  import fpq_pkg::*;
#(
  parameter int unsigned ENTRY_BUSY_CYC = SLEEP_ENTRY_BUSY_CYC,
  parameter int unsigned EXIT_WAIT_CYC  = SLEEP_EXIT_WAIT_CYC
) (
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_n,
  // pins
  input  wire logic                      i_sleep_pin,
  input  wire logic                      i_cs_n,
  input  wire logic                      i_we_n,
  input  wire logic                      i_oe_n,
  input  wire logic [fpq_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [fpq_pkg::DATA_W-1:0] i_wdata,
  output logic      [fpq_pkg::DATA_W-1:0] o_rdata,
  output logic                           o_rdata_oe,
  // variant strap: 0 bottom, 1 top, 2 uniform
  input  wire logic [1:0]                i_layout,
  // array side
  input  wire logic                      i_pe_busy,
  input  wire logic [fpq_pkg::DATA_W-1:0] i_array_data,
  output logic                           o_cmd_valid,
  output logic      [fpq_pkg::ADDR_W-1:0] o_cmd_addr,
  output logic      [fpq_pkg::DATA_W-1:0] o_cmd_data,
  output logic                           o_pe_inhibit,
  // status
  output logic                           o_asleep,
  output logic                           o_ready,
  output logic                           o_query_mode
);
  import fpq_pkg::*;

  localparam logic [CNT_W-1:0] IDLE_CNT =
    CNT_W'(SLEEP_ENTRY_IDLE_CYC);
  localparam logic [CNT_W-1:0] BUSY_CNT = CNT_W'(ENTRY_BUSY_CYC);
  localparam logic [CNT_W-1:0] WAKE_CNT = CNT_W'(EXIT_WAIT_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE  = 14'h0001;

  // ==========================================================
  // input synchronisers
  logic sleep_s;
  logic cs_n_s;
  logic we_n_s;
  logic oe_n_s;

  fpq_sync u_sync_sleep (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_sleep_pin),
    .o_sync    (sleep_s)
  );
  // idle-high strobes reset to idle so no false edge follows reset
  fpq_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_cs_n),
    .o_sync    (cs_n_s)
  );
  fpq_sync #(.RST_VAL(1'b1)) u_sync_we (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_we_n),
    .o_sync    (we_n_s)
  );
  fpq_sync #(.RST_VAL(1'b1)) u_sync_oe (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_oe_n),
    .o_sync    (oe_n_s)
  );

  // ==========================================================
  // state
  typedef struct packed {
    fpq_pwr_t               pwr;
    logic [CNT_W-1:0]       cnt;
    logic                   query;
    logic                   we_n_d;
    logic                   pe_seen;
    logic [ADDR_W-1:0]      addr_q;
    logic [DATA_W-1:0]      data_q;
    logic [DATA_W-1:0]      rdata;
    logic                   rdata_oe;
    logic                   cmd_valid;
    logic [ADDR_W-1:0]      cmd_addr;
    logic [DATA_W-1:0]      cmd_data;
    logic [ADDR_W-1:0]      addr_s1;
    logic [ADDR_W-1:0]      addr_s2;
    logic [DATA_W-1:0]      wdata_s1;
    logic [DATA_W-1:0]      wdata_s2;
    logic [1:0]             layout_s1;
    logic [1:0]             layout_s2;
  } fpq_state_t;

  fpq_state_t st_reg;
  fpq_state_t st_next;

  logic [7:0] rom_data;

  fpq_rom u_rom (
    .i_layout (st_reg.layout_s2),
    .i_addr   (st_reg.addr_s2[QADDR_W-1:0]),
    .o_data   (rom_data)
  );

  // ==========================================================
  // next state
  logic awake;
  logic wr_done;
  logic rd_act;
  logic in_table;

  always_comb begin
    st_next = st_reg;
    awake   = (st_reg.pwr == FPQ_ACTIVE) || (st_reg.pwr == FPQ_ENTER);
    // chip select only counts while awake
    wr_done = awake && !cs_n_s && we_n_s && !st_reg.we_n_d;
    rd_act  = awake && !cs_n_s && !oe_n_s && we_n_s;
    in_table = (st_reg.addr_s2[ADDR_W-1:QADDR_W] == '0);
    // address, data and strap are held stable by the host around
    // the strobes, so two flops bring them in with the strobes
    st_next.addr_s1   = i_addr;
    st_next.addr_s2   = st_reg.addr_s1;
    st_next.wdata_s1  = i_wdata;
    st_next.wdata_s2  = st_reg.wdata_s1;
    st_next.layout_s1 = i_layout;
    st_next.layout_s2 = st_reg.layout_s1;
    st_next.we_n_d    = we_n_s;
    st_next.cmd_valid = 1'b0;
    st_next.addr_q    = st_reg.addr_s2;
    st_next.data_q    = st_reg.wdata_s2;

    case (st_reg.pwr)
      FPQ_ACTIVE: begin
        if (sleep_s) begin
          st_next.pwr     = FPQ_ENTER;
          st_next.pe_seen = i_pe_busy;
          st_next.cnt     = i_pe_busy ? BUSY_CNT : IDLE_CNT;
        end
      end
      FPQ_ENTER: begin
        if (!sleep_s) begin
          st_next.pwr = FPQ_ACTIVE;
        end else if (i_pe_busy && !st_reg.pe_seen) begin
          st_next.pe_seen = 1'b1;
          st_next.cnt     = BUSY_CNT;
        end else if (st_reg.cnt <= CNT_ONE) begin
          st_next.pwr   = FPQ_SLEEP;
          st_next.query = 1'b0;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_ONE;
        end
      end
      FPQ_SLEEP: begin
        if (!sleep_s) begin
          st_next.pwr = FPQ_WAKE;
          st_next.cnt = WAKE_CNT;
        end
      end
      FPQ_WAKE: begin
        if (sleep_s) begin
          st_next.pwr = FPQ_SLEEP;
        end else if (st_reg.cnt <= CNT_ONE) begin
          st_next.pwr = FPQ_ACTIVE;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_ONE;
        end
      end
      default: begin
        st_next.pwr = FPQ_ACTIVE;
      end
    endcase

    // command decode on the rising edge of the write strobe
    // a command on the edge into sleep is lost with the circuitry
    if (wr_done && st_next.pwr != FPQ_SLEEP) begin
      if (st_reg.data_q[7:0] == CMD_RESET) begin
        st_next.query = 1'b0;
      end else if (st_reg.data_q[7:0] == CMD_QUERY &&
                   st_reg.addr_q == QUERY_ENTRY_ADDR) begin
        st_next.query = 1'b1;
      end else if (!st_reg.query && st_reg.pwr == FPQ_ACTIVE) begin
        // writes only forwarded while fully awake
        st_next.cmd_valid = 1'b1;
        st_next.cmd_addr  = st_reg.addr_q;
        st_next.cmd_data  = st_reg.data_q;
      end
    end

    // read data
    st_next.rdata_oe = rd_act;
    if (st_reg.query) begin
      st_next.rdata = {QUERY_DATA_HI, in_table ? rom_data : 8'h00};
    end else begin
      st_next.rdata = i_array_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg          <= '0;
      st_reg.pwr      <= FPQ_ACTIVE;
      st_reg.we_n_d   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata      = st_reg.rdata;
  assign o_rdata_oe   = st_reg.rdata_oe;
  assign o_cmd_valid  = st_reg.cmd_valid;
  assign o_cmd_addr   = st_reg.cmd_addr;
  assign o_cmd_data   = st_reg.cmd_data;
  assign o_asleep     = (st_reg.pwr == FPQ_SLEEP);
  assign o_pe_inhibit = (st_reg.pwr != FPQ_ACTIVE);
  assign o_ready      = (st_reg.pwr == FPQ_ACTIVE);
  assign o_query_mode = st_reg.query;
endmodule : fpq_top

// ### fpq_top_props.sv
`timescale 1ns/10ps
// ==========================================================
// port checker for the power and query block
module fpq_top_props
  import fpq_pkg::*;
#(
  parameter int EXIT_WAIT_CYC = 30
) (
  input wire logic                        i_sys_clk,
  input wire logic                        i_rst_n,
  input wire logic                        i_sleep_pin,
  input wire logic                        i_pe_busy,
  input wire logic [fpq_pkg::DATA_W-1:0]  o_rdata,
  input wire logic                        o_rdata_oe,
  input wire logic                        o_cmd_valid,
  input wire logic                        o_pe_inhibit,
  input wire logic                        o_asleep,
  input wire logic                        o_ready,
  input wire logic                        o_query_mode
);
  localparam int WAKE_MAX = EXIT_WAIT_CYC + 10;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_awake8;
    !o_asleep [*8];
  endsequence
  sequence s_pin_low8;
    !i_sleep_pin [*8];
  endsequence

  a_pin_low_awake : assert property (s_pin_low8 |-> !o_asleep)
    else $error("asleep with sleep pin low");
  a_idle_entry_time : assert property ($fell(o_ready) |-> s_awake8)
    else $error("sleep entered too early");
  a_busy_entry_time : assert property (
    $fell(o_ready) && $past(i_pe_busy) |-> s_awake8 ##1 s_awake8)
    else $error("sleep entered too early while busy");
  a_wake_bound : assert property (
    o_asleep && $fell(i_sleep_pin) |-> ##[1:WAKE_MAX] o_ready)
    else $error("wake took too long");
  a_sleep_no_read : assert property (
    o_asleep && $past(o_asleep) |-> !o_rdata_oe)
    else $error("read data driven while asleep");
  a_sleep_inhibit : assert property (o_pe_inhibit |=> !o_cmd_valid)
    else $error("write forwarded while inhibited");
  a_cmd_awake : assert property (
    o_cmd_valid |-> $past(o_ready) && !o_asleep)
    else $error("write forwarded while not active");
  a_query_hi_zero : assert property (
    o_query_mode && $past(o_query_mode, 3) && o_rdata_oe
      |-> o_rdata[15:8] == 8'h00)
    else $error("upper byte not zero in query mode");
  a_query_no_fwd : assert property (
    o_query_mode && $past(o_query_mode) |-> !o_cmd_valid)
    else $error("write forwarded in query mode");
  a_sleep_query_off : assert property (o_asleep |-> !o_query_mode)
    else $error("query mode kept while asleep");
endmodule : fpq_top_props

bind fpq_top fpq_top_props #(.EXIT_WAIT_CYC(EXIT_WAIT_CYC)) i_fpq_top_props (
  .i_sys_clk    (i_sys_clk),
  .i_rst_n      (i_rst_n),
  .i_sleep_pin  (i_sleep_pin),
  .i_pe_busy    (i_pe_busy),
  .o_rdata      (o_rdata),
  .o_rdata_oe   (o_rdata_oe),
  .o_cmd_valid  (o_cmd_valid),
  .o_pe_inhibit (o_pe_inhibit),
  .o_asleep     (o_asleep),
  .o_ready      (o_ready),
  .o_query_mode (o_query_mode)
);

// ### tb_fpq_top.sv
`timescale 1ns/10ps
// ==========================================================
// testbench
module tb_fpq_top;
  import fpq_pkg::*;
  localparam int BUSY_CYC = 20;
  localparam int EXIT_CYC = 30;
  localparam logic [23:0] TOP_TBL [39] = '{
    24'h100051, 24'h110052, 24'h120059, 24'h150040, 24'h1f0008,
    24'h200009, 24'h21000a, 24'h220012, 24'h230001, 24'h240001,
    24'h250004, 24'h260000, 24'h270019, 24'h2a0006, 24'h2b0000,
    24'h2c0002, 24'h2d0003, 24'h2e0000, 24'h2f0080, 24'h300000,
    24'h3100fe, 24'h320000, 24'h330000, 24'h340002, 24'h350000,
    24'h3c0000, 24'h400050, 24'h410052, 24'h420049, 24'h430030,
    24'h460002, 24'h470001, 24'h480000, 24'h490001, 24'h4a0001,
    24'h4b0001, 24'h4c0003, 24'h4d0003, 24'h4f0000};
  localparam logic [23:0] UNI_TBL [4] = '{
    24'h2c0001, 24'h310000, 24'h340000, 24'h4d0004};

  logic                i_sys_clk;
  logic                i_rst_n;
  logic                i_sleep_pin;
  logic                i_cs_n;
  logic                i_we_n;
  logic                i_oe_n;
  logic [ADDR_W-1:0]   i_addr;
  logic [DATA_W-1:0]   i_wdata;
  logic [DATA_W-1:0]   o_rdata;
  logic                o_rdata_oe;
  logic [1:0]          i_layout;
  logic                i_pe_busy;
  logic [DATA_W-1:0]   i_array_data;
  logic                o_cmd_valid;
  logic [ADDR_W-1:0]   o_cmd_addr;
  logic [DATA_W-1:0]   o_cmd_data;
  logic                o_pe_inhibit;
  logic                o_asleep;
  logic                o_ready;
  logic                o_query_mode;
  int                  bad_count = 0;
  int                  comparisons = 0;
  int                  fwd_cnt = 0;

  fpq_top #(.ENTRY_BUSY_CYC(BUSY_CYC), .EXIT_WAIT_CYC(EXIT_CYC)) i_fpq_top (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sleep_pin(i_sleep_pin),
    .i_cs_n(i_cs_n), .i_we_n(i_we_n), .i_oe_n(i_oe_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe),
    .i_layout(i_layout), .i_pe_busy(i_pe_busy),
    .i_array_data(i_array_data), .o_cmd_valid(o_cmd_valid),
    .o_cmd_addr(o_cmd_addr), .o_cmd_data(o_cmd_data),
    .o_pe_inhibit(o_pe_inhibit), .o_asleep(o_asleep), .o_ready(o_ready),
    .o_query_mode(o_query_mode));

  fpq_host i_fpq_host (
    .i_sys_clk(i_sys_clk), .i_rdata(o_rdata), .i_rdata_oe(o_rdata_oe),
    .o_sleep_pin(i_sleep_pin), .o_cs_n(i_cs_n), .o_we_n(i_we_n),
    .o_oe_n(i_oe_n), .o_addr(i_addr), .o_wdata(i_wdata));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    if (o_cmd_valid === 1'b1) fwd_cnt <= fwd_cnt + 1;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic rd_chk(input logic [23:0] e);
    logic [DATA_W:0] r;
    i_fpq_host.host_read({16'h0000, e[23:16]}, r);
    chk(r, {1'b1, e[15:0]});
  endtask : rd_chk

  task automatic t_query;
    logic [DATA_W:0] r;
    int n;
    i_fpq_host.host_write(QUERY_ENTRY_ADDR, {8'h00, CMD_QUERY});
    chk(o_query_mode, 1'b1);
    foreach (TOP_TBL[k]) rd_chk(TOP_TBL[k]);
    @(posedge i_sys_clk);
    i_layout <= 2'h2;
    foreach (UNI_TBL[k]) rd_chk(UNI_TBL[k]);
    @(posedge i_sys_clk);
    i_layout <= 2'h0;
    rd_chk(24'h4d0002);
    n = fwd_cnt;
    i_fpq_host.host_write(24'h000020, 16'h00aa);
    chk(o_query_mode, 1'b1);
    chk(24'(fwd_cnt), 24'(n));
    i_fpq_host.host_write(24'h000000, {8'h00, CMD_RESET});
    chk(o_query_mode, 1'b0);
    i_fpq_host.host_read(24'h000010, r);
    chk(r, {1'b1, 16'hc3a5});
    n = fwd_cnt;
    i_fpq_host.host_write(24'h0abcde, 16'h1357);
    chk(24'(fwd_cnt), 24'(n + 1));
    chk(o_cmd_addr, 24'h0abcde);
    chk(o_cmd_data, 16'h1357);
  endtask : t_query

  task automatic t_sleep(input logic busy, input int min_cyc);
    logic [DATA_W:0] r;
    int n;
    int f;
    @(posedge i_sys_clk);
    i_pe_busy <= busy;
    i_fpq_host.host_sleep(1'b1);
    n = 0;
    while (o_asleep !== 1'b1 && n < 200) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(n >= min_cyc, 1'b1);
    chk(n < 200, 1'b1);
    chk(o_pe_inhibit, 1'b1);
    f = fwd_cnt;
    i_fpq_host.host_write(24'h000100, 16'h00a0);
    chk(24'(fwd_cnt), 24'(f));
    i_fpq_host.host_read(24'h000010, r);
    chk(r[DATA_W], 1'b0);
    chk(o_asleep, 1'b1);
    i_fpq_host.host_sleep(1'b0);
    n = 0;
    while (o_ready !== 1'b1 && n < 200) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(n <= EXIT_CYC + 10, 1'b1);
    i_fpq_host.host_read(24'h000010, r);
    chk(r, {1'b1, 16'hc3a5});
    @(posedge i_sys_clk);
    i_pe_busy <= 1'b0;
  endtask : t_sleep

  // aborted entry, then a routine starting during entry
  task automatic t_sleep_edge;
    int n;
    i_fpq_host.host_write(QUERY_ENTRY_ADDR, {8'h00, CMD_QUERY});
    i_fpq_host.host_sleep(1'b1);
    repeat (5) @(posedge i_sys_clk);
    chk(o_ready, 1'b0);
    i_fpq_host.host_sleep(1'b0);
    repeat (6) @(posedge i_sys_clk);
    chk({o_ready, o_asleep, o_query_mode}, 3'b101);
    i_fpq_host.host_sleep(1'b1);
    repeat (5) @(posedge i_sys_clk);
    i_pe_busy <= 1'b1;
    n = 0;
    while (o_asleep !== 1'b1 && n < 200) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(n >= BUSY_CYC, 1'b1);
    chk(o_query_mode, 1'b0);
    i_fpq_host.host_sleep(1'b0);
    repeat (EXIT_CYC + 10) @(posedge i_sys_clk);
    chk(o_ready, 1'b1);
    i_pe_busy <= 1'b0;
  endtask : t_sleep_edge

  initial begin
    #200000;
    bad_count++;
    conclude;
  end

  initial begin
    i_rst_n = 1'b0;
    i_layout = 2'h1;
    i_pe_busy = 1'b0;
    i_array_data = 16'hc3a5;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk({o_ready, o_asleep, o_query_mode, o_pe_inhibit}, 4'b1000);
    t_query;
    t_sleep(1'b0, SLEEP_ENTRY_IDLE_CYC);
    t_sleep(1'b1, BUSY_CYC);
    t_sleep_edge;
    conclude;
  end
endmodule : tb_fpq_top
